// ==== core/uwc_consts.svh ====
// Offsets, field positions, reset values and widths of the UART write counter status block.
`ifndef UWC_CONSTS_SVH
`define UWC_CONSTS_SVH

// ==========================================================================
// Register offsets
`define UWC_ADDR_W        7
`define UWC_ADDR_STATUS   7'h01
`define UWC_ADDR_WRCNT    7'h02

// ==========================================================================
// Status field positions and reset values
`define UWC_BIT_RESET     0
`define UWC_BIT_DRV_ERR   1
`define UWC_BIT_PUMP_UV   2
`define UWC_NUM_FLAGS     3
`define UWC_STATUS_RST    3'h5
`define UWC_CNT_W         8
`define UWC_CNT_RST       8'h00
`define UWC_CNT_ONE       8'h01
`define UWC_CNT_MAX       8'hFF

`endif

// ==== core/uwc_flag_bank.sv ====
// Bank of sticky status flags: hardware sets, software clears by writing one.
`timescale 1ns/10ps
`default_nettype none

module uwc_flag_bank
    import uwc_pkg::*;
#(
    parameter int           N       = 3,
    parameter logic [N-1:0] RST_VAL = '0
) (
    input  wire logic sys_clk,  // System clock.
    input  wire logic rstn,     // Synchronous reset, active low.
    uwc_flag_if.bank  fl        // Set, clear and flag values.
);

    // A bank wider than one word could not be cleared by a single register write.
    if (N < 1 || N > 32) begin : g_bad_n
        $error("uwc_flag_bank: N must lie in 1..32");
    end

    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    // ======================================================================
    // Per-bit next value
    // A set in the same cycle as a clear wins, so an event is never lost.
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            assign flag_d[i] = fl.set[i] | (flag_q[i] & ~fl.clr[i]);
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flag_q <= RST_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign fl.flags = flag_q;

    // ======================================================================
    // Checks
    a_set_wins_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fl.set != '0) |=> ((flag_q & $past(fl.set)) == $past(fl.set)))
        else $error("A set flag was lost to a clear.");

    a_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fl.clr == '0) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
        else $error("A flag dropped without a clear.");

endmodule : uwc_flag_bank

`default_nettype wire

// ==== core/uwc_flag_if.sv ====
// Interface between the status register logic and the sticky flag bank.
`timescale 1ns/10ps
`default_nettype none

interface uwc_flag_if #(
    parameter int N = 3
);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flags;

    modport bank (input set, input clr, output flags);
    modport user (output set, output clr, input flags);
endinterface : uwc_flag_if

`default_nettype wire

// ==== core/uwc_pkg.sv ====
// Types shared by the UART write counter status block.
package uwc_pkg;

    typedef logic [7:0]  uwc_cnt_t;
    typedef logic [31:0] uwc_word_t;

    // Register selected by the current read or write.
    typedef enum logic [1:0] {
        UWC_SEL_NONE,
        UWC_SEL_STATUS,
        UWC_SEL_WRCNT
    } uwc_sel_e;

endpackage : uwc_pkg

// ==== core/uwc_top.sv ====
// Global status flags and UART write counter register bank.
`timescale 1ns/10ps
`default_nettype none
`include "uwc_consts.svh"

module uwc_top
    import uwc_pkg::*;
(
    input  wire logic                   sys_clk,       // System clock, 100 MHz.
    input  wire logic                   rstn,          // Synchronous reset, active low.
    input  wire logic                   spi_mode,      // Pin level: SPI port in use.
    input  wire logic                   drv_fault,     // Power stage shut down on a fault.
    input  wire logic                   pump_uv,       // Charge pump undervoltage level.
    input  wire logic                   uart_wr_ok,    // Pulse: UART write frame ended.
    input  wire logic                   uart_wr_fail,  // Pulse: that frame was bad.
    input  wire logic                   reg_wr,        // Pulse: register write.
    input  wire logic                   reg_rd,        // Pulse: register read.
    input  wire logic [`UWC_ADDR_W-1:0] reg_addr,      // Register address.
    input  wire logic [31:0]            reg_wdata,     // Write data.
    output logic      [31:0]            reg_rdata,     // Read data, registered.
    output logic                        reg_rvalid,    // Pulse: read data valid.
    output logic                        reset_flag,    // Reset indication flag.
    output logic                        drv_err_flag,  // Driver error flag.
    output logic                        pump_undervoltage_flag // Pump undervoltage flag.
);

    // ======================================================================
    // Input synchronisers
    // Pin levels come from outside the clock domain and pass two flops.
    logic spi_meta_q;
    logic spi_sync_q;
    logic drv_meta_q;
    logic drv_sync_q;
    logic uv_meta_q;
    logic uv_sync_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            spi_meta_q <= 1'b0;
            spi_sync_q <= 1'b0;
            drv_meta_q <= 1'b0;
            drv_sync_q <= 1'b0;
            uv_meta_q  <= 1'b0;
            uv_sync_q  <= 1'b0;
        end else begin
            spi_meta_q <= spi_mode;
            spi_sync_q <= spi_meta_q;
            drv_meta_q <= drv_fault;
            drv_sync_q <= drv_meta_q;
            uv_meta_q  <= pump_uv;
            uv_sync_q  <= uv_meta_q;
        end
    end

    // ======================================================================
    // Address decode
    uwc_sel_e sel;

    always_comb begin
        case (reg_addr)
            `UWC_ADDR_STATUS: sel = UWC_SEL_STATUS;
            `UWC_ADDR_WRCNT:  sel = UWC_SEL_WRCNT;
            default:         sel = UWC_SEL_NONE;
        endcase
    end

    // ======================================================================
    // Status flags
    uwc_flag_if #(.N(`UWC_NUM_FLAGS)) flag_bus ();
    logic status_wr;

    assign status_wr = reg_wr && (sel == UWC_SEL_STATUS);

    always_comb begin
        flag_bus.set                   = '0;
        flag_bus.set[`UWC_BIT_DRV_ERR] = drv_sync_q;
        flag_bus.set[`UWC_BIT_PUMP_UV] = uv_sync_q;
        flag_bus.clr = status_wr ? reg_wdata[`UWC_NUM_FLAGS-1:0] : '0;
    end

    // The reset flag has reset value one, so every chip reset leaves it set.
    uwc_flag_bank #(
        .N       (`UWC_NUM_FLAGS),
        .RST_VAL (`UWC_STATUS_RST)
    ) u_flags (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .fl      (flag_bus)
    );

    assign reset_flag             = flag_bus.flags[`UWC_BIT_RESET];
    assign drv_err_flag           = flag_bus.flags[`UWC_BIT_DRV_ERR];
    assign pump_undervoltage_flag = flag_bus.flags[`UWC_BIT_PUMP_UV];

    // ======================================================================
    // UART write counter
    // Writes to the counter address are ignored: the register is read only.
    uwc_cnt_t cnt_q;
    uwc_cnt_t cnt_d;
    logic     cnt_inc;

    assign cnt_inc = uart_wr_ok && !uart_wr_fail && !spi_sync_q;

    always_comb begin
        cnt_d = cnt_q;
        if (cnt_inc) begin
            cnt_d = cnt_q + `UWC_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_q <= `UWC_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ======================================================================
    // Read path
    // Reads only sample state, so they carry no side effect on the counter.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    always_comb begin
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        if (reg_rd) begin
            case (sel)
                UWC_SEL_STATUS: rdata_d = {29'h0, flag_bus.flags};
                UWC_SEL_WRCNT:  rdata_d = {24'h0, cnt_q};
                default:       rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_q  <= 32'h0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_cnt_counts_ok: assert property (
        uart_wr_ok && !uart_wr_fail && !spi_sync_q
        |=> cnt_q == $past(cnt_q) + `UWC_CNT_ONE)
        else $error("Counter missed a successful UART write.");

    a_cnt_fail_hold: assert property (
        uart_wr_ok && uart_wr_fail |=> $stable(cnt_q))
        else $error("Counter moved on a failed write.");

    a_read_no_effect: assert property (
        reg_rd && !uart_wr_ok |=> $stable(cnt_q))
        else $error("A read changed the counter.");

    a_spi_no_count: assert property (
        spi_sync_q |=> $stable(cnt_q))
        else $error("Counter moved in SPI operation.");

    a_cnt_wraps_zero: assert property (
        cnt_inc && cnt_q == `UWC_CNT_MAX |=> cnt_q == `UWC_CNT_RST)
        else $error("Counter did not wrap to zero.");

    // The second cycle may legally read zero when a clear landed after the fault went away.
    a_drv_err_set: assert property (
        drv_sync_q |=> drv_err_flag ##1
        (drv_err_flag || $past(status_wr && reg_wdata[`UWC_BIT_DRV_ERR])))
        else $error("Driver error flag not set on fault.");

    a_pump_uv_set: assert property (
        uv_sync_q && status_wr |=> pump_undervoltage_flag)
        else $error("Undervoltage flag lost while condition present.");

    a_uv_flag_set: assert property (
        uv_sync_q |=> pump_undervoltage_flag)
        else $error("Undervoltage flag not set on undervoltage.");

    a_reset_flag_set: assert property (disable iff (1'b0)
        !rstn ##1 rstn |-> reset_flag)
        else $error("Reset flag not set after reset.");

    a_w1c_clears: assert property (
        status_wr && reg_wdata[`UWC_BIT_RESET] |=> !reset_flag)
        else $error("Writing one did not clear the reset flag.");

    a_read_counter: assert property (
        reg_rd && sel == UWC_SEL_WRCNT
        |=> reg_rvalid && reg_rdata == {24'h0, $past(cnt_q)})
        else $error("Counter read returned the wrong value.");

    a_read_status: assert property (
        reg_rd && sel == UWC_SEL_STATUS
        |=> reg_rvalid && reg_rdata == {29'h0, $past(flag_bus.flags)})
        else $error("Status read returned the wrong value.");

    c_cnt_wrap:    cover property (cnt_inc && cnt_q == `UWC_CNT_MAX);
    c_flag_clear:  cover property (status_wr && reg_wdata[`UWC_BIT_DRV_ERR] && drv_err_flag);
    c_spi_frame:   cover property (uart_wr_ok && spi_sync_q);
    c_read_status: cover property (reg_rd && sel == UWC_SEL_STATUS);
    c_fail_frame:  cover property (uart_wr_ok && uart_wr_fail);

endmodule : uwc_top

`default_nettype wire

// ==== test/test_uart_write_counter_status.sv ====
// Self-checking testbench of the UART write counter status block.
`timescale 1ns/10ps
`default_nettype none
`include "uwc_consts.svh"

module test_uart_write_counter_status;
    import uwc_pkg::*;
    logic                   sys_clk, rstn, spi_mode, drv_fault, pump_uv;
    wire logic              reg_wr, reg_rd, reg_rvalid, uart_wr_ok, uart_wr_fail;
    wire logic              reset_flag, drv_err_flag, pump_undervoltage_flag;
    wire logic [`UWC_ADDR_W-1:0] reg_addr;
    wire uwc_word_t         reg_wdata, reg_rdata;
    int                     err_total, n_checks, cnt_m, i, b;
    logic [2:0]             st_m;
    logic [31:0]            rnd;
    bit                     fl;

    uwc_top dut (.sys_clk(sys_clk), .rstn(rstn), .spi_mode(spi_mode),
        .drv_fault(drv_fault), .pump_uv(pump_uv), .uart_wr_ok(uart_wr_ok),
        .uart_wr_fail(uart_wr_fail), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reset_flag(reset_flag), .drv_err_flag(drv_err_flag),
        .pump_undervoltage_flag(pump_undervoltage_flag));
    uwc_host_model host (.sys_clk(sys_clk), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .uart_wr_ok(uart_wr_ok), .uart_wr_fail(uart_wr_fail));

    // ======================================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic conclude();
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input uwc_word_t exp, input uwc_word_t seen);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // A read that never answers ends the run at once.
    task automatic rd_chk(input logic [`UWC_ADDR_W-1:0] a, input uwc_word_t e, input string nm);
        uwc_word_t d;
        bit        ok;
        host.rd(a, d, ok);
        if (!ok) begin
            err_total++;
            $display("ERROR %s expected valid seen none", nm);
            conclude();
        end
        chk(nm, e, d);
    endtask : rd_chk

    task automatic chk_flags();
        chk("flags", {29'h0, st_m}, {29'h0, pump_undervoltage_flag, drv_err_flag, reset_flag});
    endtask : chk_flags

    // ======================================================================
    // Stimulus
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        {rstn, spi_mode, drv_fault, pump_uv} = 4'h0;
        err_total = 0;
        n_checks  = 0;
        cnt_m     = 0;
        st_m      = `UWC_STATUS_RST;
        rnd       = 32'hC173;
        repeat (10) @(posedge sys_clk);
        #1 rstn = 1'b1;
        chk_flags();
        rd_chk(`UWC_ADDR_STATUS, 32'h5, "status");
        rd_chk(`UWC_ADDR_WRCNT, 32'h0, "counter");
        rd_chk(7'h00, 32'h0, "unmapped");
        host.wr(`UWC_ADDR_STATUS, 32'h0);
        host.wr(7'h00, 32'h7);
        rd_chk(`UWC_ADDR_STATUS, 32'h5, "status");
        host.wr(`UWC_ADDR_STATUS, 32'h7);
        st_m = 3'h0;
        rd_chk(`UWC_ADDR_STATUS, 32'h0, "status");
        // After each counter write the count is read twice against the model; enough frames to wrap.
        for (i = 0; i < 600; i++) begin
            rnd = lfsr_next(rnd);
            if (i == 120 || i == 180) begin
                spi_mode = (i == 120);
                repeat (5) @(posedge sys_clk);
            end
            fl = (rnd[1:0] == 2'h0);
            host.frame(fl);
            if (!fl && !spi_mode) cnt_m = (cnt_m + 1) % 256;
            if (i % 41 == 0) begin
                host.wr(`UWC_ADDR_WRCNT, rnd);
                rd_chk(`UWC_ADDR_WRCNT, uwc_word_t'(cnt_m), "counter");
                rd_chk(`UWC_ADDR_WRCNT, uwc_word_t'(cnt_m), "counter");
            end
        end
        rd_chk(`UWC_ADDR_WRCNT, uwc_word_t'(cnt_m), "counter");
        for (b = 1; b < 3; b++) begin
            @(posedge sys_clk) #1;
            if (b == 1) drv_fault = 1'b1;
            else pump_uv = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 st_m[b] = 1'b1;
            chk_flags();
            host.wr(`UWC_ADDR_STATUS, uwc_word_t'(1 << b));
            rd_chk(`UWC_ADDR_STATUS, {29'h0, st_m}, "status");
            {drv_fault, pump_uv} = 2'h0;
            repeat (4) @(posedge sys_clk);
            host.wr(`UWC_ADDR_STATUS, uwc_word_t'(1 << b));
            st_m[b] = 1'b0;
            rd_chk(`UWC_ADDR_STATUS, {29'h0, st_m}, "status");
        end
        @(posedge sys_clk) #1 rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rstn = 1'b1;
        st_m = `UWC_STATUS_RST;
        chk_flags();
        rd_chk(`UWC_ADDR_WRCNT, 32'h0, "counter");
        conclude();
    end
endmodule : test_uart_write_counter_status

`default_nettype wire

// ==== test/uwc_host_model.sv ====
// Host controller model: drives the register port and the UART frame events.
`timescale 1ns/10ps
`default_nettype none
`include "uwc_consts.svh"

module uwc_host_model
    import uwc_pkg::*;
(
    input  wire logic                   sys_clk,      // System clock.
    input  wire logic                   reg_rvalid,   // Read data valid.
    input  wire uwc_word_t              reg_rdata,    // Read data.
    output var  logic                   reg_wr,       // Register write pulse.
    output var  logic                   reg_rd,       // Register read pulse.
    output var  logic [`UWC_ADDR_W-1:0] reg_addr,     // Register address.
    output var  uwc_word_t              reg_wdata,    // Write data.
    output var  logic                   uart_wr_ok,   // Frame end pulse.
    output var  logic                   uart_wr_fail  // Frame failed.
);
    // ======================================================================
    // Idle levels
    initial begin
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_addr     = '0;
        reg_wdata    = '0;
        uart_wr_ok   = 1'b0;
        uart_wr_fail = 1'b0;
    end

    // ======================================================================
    // Transfers
    // Released address and data show the inverse, so no stale value looks valid.
    task automatic wr(input logic [`UWC_ADDR_W-1:0] a, input uwc_word_t d);
        @(posedge sys_clk) #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge sys_clk) #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [`UWC_ADDR_W-1:0] a, output uwc_word_t d, output bit ok);
        int i;
        ok = 1'b0;
        d  = '0;
        @(posedge sys_clk) #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge sys_clk) #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        for (i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end else begin
                @(posedge sys_clk) #1;
            end
        end
    endtask : rd

    task automatic frame(input bit fail);
        @(posedge sys_clk) #1;
        uart_wr_ok   = 1'b1;
        uart_wr_fail = fail;
        @(posedge sys_clk) #1;
        uart_wr_ok   = 1'b0;
        uart_wr_fail = 1'b0;
    endtask : frame
endmodule : uwc_host_model

`default_nettype wire
